// File: verilog/fbs_consts.vh
`ifndef FBS_CONSTS_VH
`define FBS_CONSTS_VH
// ***************************************
// Buffer word addresses
// ***************************************
`define FBS_IN_FIRST 12'h0100
`define FBS_IN_LAST 12'h01bf
`define FBS_OP_STN 12'h0201
`define FBS_STN_REQ 12'h0203
`define FBS_ERR_CODE 12'h07f8
`define FBS_TRB_FIRST 12'h07f9
`define FBS_TRB_LAST 12'h0805
`define FBS_CUR_MODE 12'h08ce
`define FBS_MODE_REQ 12'h08cf
`define FBS_MODE_RES 12'h08d0
`define FBS_WDT_VAL 12'h08d1
// ***************************************
// Values and reset values
// ***************************************
`define FBS_WDT_MIN 16'h0002
`define FBS_WDT_MAX 16'hfe01
`define FBS_STN_ERR 16'h1002
`define FBS_STN_MAX 16'h007d
`define FBS_STN_RST 16'h0001
`define FBS_MODE_MAX 16'h0003
`define FBS_MODE_RST 16'h0000
`define FBS_MODE_OK 16'h0000
`define FBS_MODE_FAIL 16'h0001
`define FBS_ZERO 16'h0000
`endif

// File: verilog/fbs_buf_mem.v
`timescale 1ns/1ps
module fbs_buf_mem (
  // Clock
  input wire i_core_clk,
  // Host port, read and write
  input wire i_a_we,
  input wire [11:0] i_a_addr,
  input wire [15:0] i_a_wdata,
  output reg [15:0] o_a_rdata,
  // Link port, read only
  input wire [11:0] i_b_addr,
  output reg [15:0] o_b_rdata
);
  reg [15:0] mem_r [0:4095];

  // No reset: contents are undefined until the host writes them
  always @(posedge i_core_clk) begin
    if (i_a_we) begin
      mem_r[i_a_addr] <= i_a_wdata;
    end
    o_a_rdata <= mem_r[i_a_addr];
    o_b_rdata <= mem_r[i_b_addr];
  end
endmodule // fbs_buf_mem

// File: verilog/fbs_host_if.v
`timescale 1ns/1ps
`include "fbs_consts.vh"
module fbs_host_if (
  // Clock and reset
  input wire i_core_clk,
  input wire i_rst,
  // Host request signals
  input wire i_input_refresh_enable,
  input wire i_trouble_notify_req,
  input wire i_error_reset_req,
  input wire i_mode_change_req,
  input wire i_station_set_req,
  // Host buffer port
  input wire i_host_wr,
  input wire i_host_rd,
  input wire [11:0] i_host_addr,
  input wire [15:0] i_host_wdata,
  output reg [15:0] o_host_rdata,
  output reg o_host_rvalid,
  // Master side events
  input wire i_link_start,
  input wire i_comm_timeout,
  input wire i_comm_stop,
  input wire i_freeze_cmd,
  input wire i_unfreeze_cmd,
  input wire i_addr_lock,
  input wire i_cycle_req,
  input wire [15:0] i_link_wdt_value,
  // Internal faults
  input wire i_wdt_error,
  input wire i_hw_fault,
  // Host status flags
  output reg o_link_active_flag,
  output reg o_trouble_notify_done,
  output reg o_module_error_flag,
  output reg o_freeze_mode_flag,
  output reg o_module_wdt_error_flag,
  output reg o_mode_change_done,
  output reg o_station_set_done,
  output reg o_module_ready_flag,
  // Indicators
  output reg o_freeze_indicator,
  output reg o_error_indicator,
  // Transmit stream to master
  output reg o_tx_valid,
  output reg [15:0] o_tx_data,
  output reg o_tx_last,
  output reg o_tx_diag,
  output reg o_io_suspended
);
  // ***************************************
  // States
  // ***************************************
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_IO = 2'b01;
  localparam [1:0] ST_DIAG = 2'b10;

  // ***************************************
  // Request edge detection
  // ***************************************
  reg trb_d_r;
  reg ers_d_r;
  reg mcr_d_r;
  reg stn_d_r;
  wire trb_rise = i_trouble_notify_req & ~trb_d_r;
  wire ers_rise = i_error_reset_req & ~ers_d_r;
  wire mcr_rise = i_mode_change_req & ~mcr_d_r;
  wire stn_rise = i_station_set_req & ~stn_d_r;

  always @(posedge i_core_clk) begin
    if (i_rst) begin
      trb_d_r <= 1'b0;
      ers_d_r <= 1'b0;
      mcr_d_r <= 1'b0;
      stn_d_r <= 1'b0;
    end else begin
      trb_d_r <= i_trouble_notify_req;
      ers_d_r <= i_error_reset_req;
      mcr_d_r <= i_mode_change_req;
      stn_d_r <= i_station_set_req;
    end
  end

  // ***************************************
  // Registers and flags
  // ***************************************
  reg [15:0] op_stn_r;
  reg [15:0] stn_req_r;
  reg [15:0] err_code_r;
  reg [15:0] cur_mode_r;
  reg [15:0] mode_req_r;
  reg [15:0] mode_res_r;
  reg [15:0] wdt_val_r;
  reg lock_r;
  reg stn_busy_r;
  reg trb_pend_r;
  reg [1:0] st_r;
  reg [11:0] rd_addr_r;
  reg [11:0] end_addr_r;
  reg zero_r;
  reg iss_v_r;
  reg iss_last_r;
  reg iss_diag_r;
  reg iss_zero_r;
  wire [15:0] mem_a_rdata;
  wire [15:0] mem_b_rdata;

  wire wdt_valid = (wdt_val_r >= `FBS_WDT_MIN) && (wdt_val_r <= `FBS_WDT_MAX);
  wire timeout_ev = i_comm_timeout & wdt_valid;
  wire stn_bad = (stn_req_r > `FBS_STN_MAX) || lock_r;
  wire stn_apply = stn_busy_r;
  wire stn_err = stn_apply & stn_bad;
  wire wr_stn_req = i_host_wr && (i_host_addr == `FBS_STN_REQ);
  wire wr_mode_req = i_host_wr && (i_host_addr == `FBS_MODE_REQ);
  wire last_diag = iss_v_r & iss_diag_r & iss_last_r;
  wire wdt_err_nxt = o_module_wdt_error_flag | i_wdt_error;
  wire freeze_nxt = (i_unfreeze_cmd | i_comm_stop | timeout_ev) ? 1'b0 :
                    (i_freeze_cmd ? 1'b1 : o_freeze_mode_flag);
  wire err_nxt = stn_err | (o_module_error_flag & ~ers_rise);

  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_link_active_flag <= 1'b0;
      o_freeze_mode_flag <= 1'b0;
      o_freeze_indicator <= 1'b0;
      o_module_wdt_error_flag <= 1'b0;
      o_module_ready_flag <= 1'b0;
      o_module_error_flag <= 1'b0;
      o_error_indicator <= 1'b0;
      o_mode_change_done <= 1'b0;
      o_station_set_done <= 1'b0;
      o_trouble_notify_done <= 1'b0;
      o_io_suspended <= 1'b0;
      op_stn_r <= `FBS_STN_RST;
      stn_req_r <= `FBS_ZERO;
      err_code_r <= `FBS_ZERO;
      cur_mode_r <= `FBS_MODE_RST;
      mode_req_r <= `FBS_ZERO;
      mode_res_r <= `FBS_MODE_OK;
      wdt_val_r <= `FBS_ZERO;
      lock_r <= 1'b0;
      stn_busy_r <= 1'b0;
      trb_pend_r <= 1'b0;
    end else begin
      wdt_val_r <= i_link_wdt_value;
      // Link active: a master start in the timeout cycle wins
      if (i_link_start) begin
        o_link_active_flag <= 1'b1;
      end else if (timeout_ev) begin
        o_link_active_flag <= 1'b0;
      end
      // Clear wins over a freeze in the same cycle
      o_freeze_mode_flag <= freeze_nxt;
      o_freeze_indicator <= freeze_nxt;
      o_module_wdt_error_flag <= wdt_err_nxt;
      o_module_ready_flag <= ~(wdt_err_nxt | i_hw_fault);
      // A new error in the reset cycle is kept
      o_module_error_flag <= err_nxt;
      o_error_indicator <= err_nxt;
      if (stn_err) begin
        err_code_r <= `FBS_STN_ERR;
      end else if (ers_rise) begin
        err_code_r <= `FBS_ZERO;
      end
      // Host writable request words
      if (wr_stn_req) begin
        stn_req_r <= i_host_wdata;
      end
      if (wr_mode_req) begin
        mode_req_r <= i_host_wdata;
      end
      // Lock: set wins over a same-cycle cancel
      if (i_addr_lock) begin
        lock_r <= 1'b1;
      end else if (wr_stn_req && (i_host_wdata == `FBS_ZERO)) begin
        lock_r <= 1'b0;
      end
      // Mode change, applied on the request edge
      if (mcr_rise) begin
        if (mode_req_r <= `FBS_MODE_MAX) begin
          cur_mode_r <= mode_req_r;
          mode_res_r <= `FBS_MODE_OK;
        end else begin
          mode_res_r <= `FBS_MODE_FAIL;
        end
      end
      o_mode_change_done <= i_mode_change_req & (o_mode_change_done | mcr_rise);
      // Station change: one cycle of suspension, then apply
      stn_busy_r <= stn_rise;
      if (stn_apply & ~stn_bad) begin
        op_stn_r <= stn_req_r;
      end
      o_station_set_done <= i_station_set_req & (o_station_set_done | stn_apply);
      o_io_suspended <= stn_rise;
      // Trouble request only taken while link is active
      if (trb_rise & o_link_active_flag) begin
        trb_pend_r <= 1'b1;
      end else if (st_r == ST_IDLE) begin
        trb_pend_r <= 1'b0;
      end
      o_trouble_notify_done <= i_trouble_notify_req &
                               (o_trouble_notify_done | last_diag);
    end
  end

  // ***************************************
  // Transmit sequencer
  // ***************************************
  // Cycle requests that arrive while busy are dropped, not queued
  wire io_go = i_cycle_req & o_link_active_flag & ~stn_rise & ~stn_busy_r;
  wire refresh_on = i_input_refresh_enable & o_link_active_flag;

  always @(posedge i_core_clk) begin
    if (i_rst) begin
      st_r <= ST_IDLE;
      rd_addr_r <= 12'h0000;
      end_addr_r <= 12'h0000;
      zero_r <= 1'b0;
      iss_v_r <= 1'b0;
      iss_last_r <= 1'b0;
      iss_diag_r <= 1'b0;
      iss_zero_r <= 1'b0;
    end else begin
      iss_v_r <= 1'b0;
      iss_last_r <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (trb_pend_r) begin
            st_r <= ST_DIAG;
            rd_addr_r <= `FBS_TRB_FIRST;
            end_addr_r <= `FBS_TRB_LAST;
            zero_r <= 1'b0;
          end else if (io_go) begin
            st_r <= ST_IO;
            rd_addr_r <= `FBS_IN_FIRST;
            end_addr_r <= `FBS_IN_LAST;
            zero_r <= ~refresh_on;
          end
        end
        ST_IO, ST_DIAG: begin
          iss_v_r <= 1'b1;
          iss_diag_r <= (st_r == ST_DIAG);
          iss_zero_r <= zero_r;
          if (rd_addr_r == end_addr_r) begin
            iss_last_r <= 1'b1;
            st_r <= ST_IDLE;
          end else begin
            rd_addr_r <= rd_addr_r + 12'h0001;
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Output stage follows the registered memory read
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_tx_valid <= 1'b0;
      o_tx_data <= `FBS_ZERO;
      o_tx_last <= 1'b0;
      o_tx_diag <= 1'b0;
    end else begin
      o_tx_valid <= iss_v_r;
      o_tx_data <= (iss_v_r & ~iss_zero_r) ? mem_b_rdata : `FBS_ZERO;
      o_tx_last <= iss_last_r;
      o_tx_diag <= iss_v_r & iss_diag_r;
    end
  end

  // ***************************************
  // Host buffer access
  // ***************************************
  // Only the two writable areas reach the memory
  wire in_area = (i_host_addr >= `FBS_IN_FIRST) && (i_host_addr <= `FBS_IN_LAST);
  wire trb_area = (i_host_addr >= `FBS_TRB_FIRST) && (i_host_addr <= `FBS_TRB_LAST);
  reg [15:0] word_val;
  reg mem_sel_r;
  reg rd_pend_r;
  reg [15:0] word_val_r;

  always @* begin
    case (i_host_addr)
      `FBS_OP_STN: word_val = op_stn_r;
      `FBS_STN_REQ: word_val = stn_req_r;
      `FBS_ERR_CODE: word_val = err_code_r;
      `FBS_CUR_MODE: word_val = cur_mode_r;
      `FBS_MODE_REQ: word_val = mode_req_r;
      `FBS_MODE_RES: word_val = mode_res_r;
      `FBS_WDT_VAL: word_val = wdt_val_r;
      default: word_val = `FBS_ZERO;
    endcase
  end

  always @(posedge i_core_clk) begin
    if (i_rst) begin
      mem_sel_r <= 1'b0;
      rd_pend_r <= 1'b0;
      word_val_r <= `FBS_ZERO;
      o_host_rdata <= `FBS_ZERO;
      o_host_rvalid <= 1'b0;
    end else begin
      rd_pend_r <= i_host_rd;
      mem_sel_r <= in_area | trb_area;
      word_val_r <= word_val;
      o_host_rvalid <= rd_pend_r;
      if (rd_pend_r) begin
        o_host_rdata <= mem_sel_r ? mem_a_rdata : word_val_r;
      end
    end
  end

  fbs_buf_mem u_mem (
    .i_core_clk(i_core_clk),
    .i_a_we(i_host_wr & (in_area | trb_area)),
    .i_a_addr(i_host_addr),
    .i_a_wdata(i_host_wdata),
    .o_a_rdata(mem_a_rdata),
    .i_b_addr(rd_addr_r),
    .o_b_rdata(mem_b_rdata)
  );
endmodule // fbs_host_if

// File: verification/fbs_host_chk.sv
`timescale 1ns/1ps
module fbs_host_chk (
  // Clock and reset
  input wire i_core_clk,
  input wire i_rst,
  // Requests and events
  input wire i_freeze_cmd,
  input wire i_unfreeze_cmd,
  input wire i_comm_stop,
  input wire i_comm_timeout,
  input wire i_wdt_error,
  input wire i_error_reset_req,
  input wire i_mode_change_req,
  input wire i_station_set_req,
  // Flags
  input wire o_freeze_mode_flag,
  input wire o_freeze_indicator,
  input wire o_module_wdt_error_flag,
  input wire o_mode_change_done,
  input wire o_station_set_done,
  input wire o_io_suspended,
  input wire o_module_error_flag
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // ***
  // Properties
  // ***
  sequence s_stn;
    o_io_suspended ##1 o_station_set_done;
  endsequence
  property p_ind; o_freeze_indicator == o_freeze_mode_flag; endproperty
  property p_frz_set;
    i_freeze_cmd && !i_unfreeze_cmd && !i_comm_stop && !i_comm_timeout |=> o_freeze_mode_flag;
  endproperty
  property p_frz_clr; i_unfreeze_cmd || i_comm_stop |=> !o_freeze_mode_flag; endproperty
  property p_wdt; i_wdt_error || o_module_wdt_error_flag |=> o_module_wdt_error_flag; endproperty
  property p_mode; $rose(i_mode_change_req) |=> o_mode_change_done; endproperty
  property p_mode_drop; !i_mode_change_req && o_mode_change_done |=> !o_mode_change_done; endproperty
  property p_stn; $rose(i_station_set_req) |=> s_stn; endproperty
  // Station error in the same cycle wins, so skip it
  property p_err; $rose(i_error_reset_req) && !o_io_suspended |=> !o_module_error_flag; endproperty
  a_ind: assert property (p_ind) else $error("freeze indicator differs");
  a_frz_set: assert property (p_frz_set) else $error("freeze not set");
  a_frz_clr: assert property (p_frz_clr) else $error("freeze not cleared");
  a_wdt: assert property (p_wdt) else $error("watchdog flag lost");
  a_mode: assert property (p_mode) else $error("mode done late");
  a_mode_drop: assert property (p_mode_drop) else $error("mode done stuck");
  a_stn: assert property (p_stn) else $error("station sequence wrong");
  a_err: assert property (p_err) else $error("error flag not cleared");
endmodule // fbs_host_chk

// File: verification/fbs_master_mdl.sv
`timescale 1ns/1ps
module fbs_master_mdl (
  // Stream from slave
  input wire i_core_clk,
  input wire i_tx_valid,
  input wire [15:0] i_tx_data,
  input wire i_tx_last,
  input wire i_tx_diag
);
  integer run_r = 0;
  integer cnt_r = 0;
  integer nfr_r = 0;
  reg [15:0] first_r;
  reg [15:0] last_r;
  reg diag_r;
  // ***
  // Frame capture; no back-pressure exists
  // ***
  always @(posedge i_core_clk) begin
    if (i_tx_valid) begin
      run_r <= i_tx_last ? 0 : run_r + 1;
      if (run_r == 0) first_r <= i_tx_data;
      if (i_tx_last) begin
        cnt_r <= run_r + 1;
        last_r <= i_tx_data;
        diag_r <= i_tx_diag;
        nfr_r <= nfr_r + 1;
      end
    end
  end
endmodule // fbs_master_mdl

// File: verification/tb_top.sv
`timescale 1ns/1ps
`include "fbs_consts.vh"
module tb_top;
  logic i_core_clk, i_rst, i_input_refresh_enable, i_trouble_notify_req, i_error_reset_req;
  logic i_mode_change_req, i_station_set_req, i_host_wr, i_host_rd, i_link_start;
  logic i_comm_timeout, i_comm_stop, i_freeze_cmd, i_unfreeze_cmd, i_addr_lock;
  logic i_cycle_req, i_wdt_error, i_hw_fault;
  logic [11:0] i_host_addr;
  logic [15:0] i_host_wdata, i_link_wdt_value;
  wire [15:0] o_host_rdata, o_tx_data;
  wire o_host_rvalid, o_link_active_flag, o_trouble_notify_done, o_module_error_flag;
  wire o_freeze_mode_flag, o_module_wdt_error_flag, o_mode_change_done, o_station_set_done;
  wire o_module_ready_flag, o_freeze_indicator, o_error_indicator, o_tx_valid, o_tx_last;
  wire o_tx_diag, o_io_suspended;
  wire [3:0] dn = {!o_module_error_flag, o_station_set_done, o_mode_change_done,
    o_trouble_notify_done};
  int err_count = 0;
  int n_tests = 0;
  fbs_host_if fbs_host_if_inst (.*);
  fbs_master_mdl fbs_master_mdl_inst (
    .i_core_clk(i_core_clk),
    .i_tx_valid(o_tx_valid),
    .i_tx_data(o_tx_data),
    .i_tx_last(o_tx_last),
    .i_tx_diag(o_tx_diag)
  );
  // ***
  // Shared tasks
  // ***
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task c1(input logic g, input logic e);
    chk({15'h0000, g}, {15'h0000, e});
  endtask
  task cyc(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [15:0] d);
    i_host_addr = a;
    i_host_wdata = d;
    pulse(i_host_wr);
  endtask
  task rd(input logic [11:0] a, input logic [15:0] e);
    i_host_addr = a;
    pulse(i_host_rd);
    cyc(1);
    c1(o_host_rvalid, 1'b1);
    chk(o_host_rdata, e);
  endtask
  // Host keeps the request up until the answer is seen
  task automatic hs(ref logic r, input int k);
    int i;
    r = 1'b1;
    for (i = 0; i < 40 && dn[k] !== 1'b1; i++) cyc(1);
    c1(dn[k], 1'b1);
    r = 1'b0;
    cyc(2);
    c1(dn[k], k == 3);
  endtask
  task frame;
    int i, s;
    s = fbs_master_mdl_inst.nfr_r;
    pulse(i_cycle_req);
    for (i = 0; i < 300 && fbs_master_mdl_inst.nfr_r == s; i++) cyc(1);
  endtask
  task see(input logic [15:0] n, f, l, input logic d);
    chk(16'(fbs_master_mdl_inst.cnt_r), n);
    chk(fbs_master_mdl_inst.first_r, f);
    chk(fbs_master_mdl_inst.last_r, l);
    c1(fbs_master_mdl_inst.diag_r, d);
  endtask
  task test_done;
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ***
  // Scenarios
  // ***
  task t_station;
    c1(o_module_ready_flag, 1'b1);
    rd(`FBS_OP_STN, 16'h0001);
    rd(12'h300, 16'h0000);
    wr(`FBS_STN_REQ, 16'h0005);
    hs(i_station_set_req, 2);
    rd(`FBS_OP_STN, 16'h0005);
    wr(`FBS_STN_REQ, 16'h007e);
    hs(i_station_set_req, 2);
    rd(`FBS_OP_STN, 16'h0005);
    rd(`FBS_ERR_CODE, `FBS_STN_ERR);
    c1(o_error_indicator, 1'b1);
    hs(i_error_reset_req, 3);
    rd(`FBS_ERR_CODE, 16'h0000);
    pulse(i_addr_lock);
    wr(`FBS_STN_REQ, 16'h007d);
    hs(i_station_set_req, 2);
    rd(`FBS_OP_STN, 16'h0005);
    hs(i_error_reset_req, 3);
    wr(`FBS_STN_REQ, 16'h0000);
    wr(`FBS_STN_REQ, 16'h007d);
    hs(i_station_set_req, 2);
    rd(`FBS_OP_STN, 16'h007d);
  endtask
  task t_mode;
    for (int m = 0; m < 5; m++) begin
      wr(`FBS_MODE_REQ, 16'(m));
      hs(i_mode_change_req, 1);
      rd(`FBS_MODE_RES, 16'(m > 3));
      rd(`FBS_CUR_MODE, 16'(m > 3 ? 3 : m));
    end
  endtask
  task t_freeze;
    pulse(i_link_start);
    pulse(i_freeze_cmd);
    c1(o_freeze_indicator, 1'b1);
    pulse(i_comm_timeout);
    c1(o_freeze_mode_flag, 1'b1);
    c1(o_link_active_flag, 1'b1);
    pulse(i_unfreeze_cmd);
    c1(o_freeze_indicator, 1'b0);
    pulse(i_freeze_cmd);
    pulse(i_comm_stop);
    c1(o_freeze_mode_flag, 1'b0);
    i_link_wdt_value = `FBS_WDT_MIN;
    pulse(i_freeze_cmd);
    pulse(i_comm_timeout);
    c1(o_freeze_mode_flag, 1'b0);
    c1(o_link_active_flag, 1'b0);
    rd(`FBS_WDT_VAL, `FBS_WDT_MIN);
    i_input_refresh_enable = 1'b1;
    frame;
    chk(16'(fbs_master_mdl_inst.nfr_r), 16'h0000);
    i_trouble_notify_req = 1'b1;
    cyc(40);
    c1(o_trouble_notify_done, 1'b0);
    i_trouble_notify_req = 1'b0;
  endtask
  task t_tx;
    int n;
    wr(`FBS_IN_FIRST, 16'habcd);
    wr(`FBS_IN_LAST, 16'h1234);
    wr(`FBS_TRB_FIRST, 16'h00aa);
    wr(`FBS_TRB_LAST, 16'h00bb);
    pulse(i_link_start);
    frame;
    see(16'h00c0, 16'habcd, 16'h1234, 1'b0);
    i_input_refresh_enable = 1'b0;
    frame;
    see(16'h00c0, 16'h0000, 16'h0000, 1'b0);
    // Cycle requests in the station change window must not start a frame
    n = fbs_master_mdl_inst.nfr_r;
    i_station_set_req = 1'b1;
    pulse(i_cycle_req);
    pulse(i_cycle_req);
    cyc(200);
    chk(16'(fbs_master_mdl_inst.nfr_r), 16'(n));
    c1(o_station_set_done, 1'b1);
    i_station_set_req = 1'b0;
    cyc(2);
    c1(o_station_set_done, 1'b0);
    hs(i_trouble_notify_req, 0);
    see(16'h000d, 16'h00aa, 16'h00bb, 1'b1);
  endtask
  task t_fault;
    pulse(i_freeze_cmd);
    pulse(i_wdt_error);
    cyc(8);
    c1(o_module_wdt_error_flag, 1'b1);
    c1(o_module_ready_flag, 1'b0);
    i_rst = 1'b1;
    cyc(2);
    i_rst = 1'b0;
    cyc(2);
    c1(o_module_wdt_error_flag, 1'b0);
    c1(o_freeze_mode_flag, 1'b0);
    c1(o_module_ready_flag, 1'b1);
    i_hw_fault = 1'b1;
    cyc(3);
    c1(o_module_ready_flag, 1'b0);
  endtask
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  // Whole run is about a thousand cycles
  initial begin
    #300_000;
    err_count++;
    test_done;
  end
  initial begin
    {i_input_refresh_enable, i_trouble_notify_req, i_error_reset_req, i_mode_change_req} = '0;
    {i_station_set_req, i_host_wr, i_host_rd, i_link_start, i_comm_timeout, i_comm_stop} = '0;
    {i_freeze_cmd, i_unfreeze_cmd, i_addr_lock, i_cycle_req, i_wdt_error, i_hw_fault} = '0;
    {i_host_addr, i_host_wdata, i_link_wdt_value} = '0;
    i_rst = 1'b1;
    cyc(10);
    i_rst = 1'b0;
    cyc(2);
    t_station;
    t_mode;
    t_freeze;
    t_tx;
    t_fault;
    test_done;
  end
endmodule // tb_top
bind fbs_host_if fbs_host_chk fbs_host_chk_inst (.*);
